// ### inc/fsp_pkg.sv
package fsp_pkg;
  localparam int NUM_PORTS = 2;
  localparam int WORD_BITS = 8;
  localparam int FIFO_DEPTH = 4;
  localparam int ADDR_BITS = 12;

  // Register byte offsets inside one port window, and the window stride.
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_DIV = 4'h4;
  localparam logic [3:0] OFS_DATA = 4'h8;
  localparam logic [3:0] OFS_STATUS = 4'hC;
  localparam int PORT_STRIDE = 16;

  // Control register fields.
  localparam int CTRL_TX_CLK_OUT = 0;
  localparam int CTRL_TX_FS_OUT = 1;
  localparam int CTRL_RX_CLK_OUT = 2;
  localparam int CTRL_RX_FS_OUT = 3;
  localparam int CTRL_TX_FALL = 4;
  localparam int CTRL_RX_FALL = 5;
  localparam int CTRL_BITS = 6;
  localparam logic [CTRL_BITS-1:0] CTRL_RESET = 6'h00;

  // Status register fields.
  localparam int STAT_TX_FULL = 0;
  localparam int STAT_TX_EMPTY = 1;
  localparam int STAT_RX_VALID = 2;
  localparam int STAT_RX_OVF = 3;

  // Bit clock limits and the derived range of the half-period divider.
  localparam longint PCLK_HZ = 10000000;
  localparam longint BCLK_MIN_HZ = 512000;
  localparam longint BCLK_MAX_HZ = 8192000;
  localparam int DIV_BITS = 4;
  localparam logic [DIV_BITS-1:0] DIV_MAX = DIV_BITS'(PCLK_HZ / (2 * BCLK_MIN_HZ) - 1);
  localparam logic [DIV_BITS-1:0] DIV_MIN = DIV_BITS'(0);
  localparam logic [DIV_BITS-1:0] DIV_RESET = DIV_MAX;
  localparam logic [WORD_BITS-1:0] IDLE_WORD = 8'hFF;

  typedef struct packed {
    logic tx_bit_clock;
    logic tx_frame_sync;
    logic rx_bit_clock;
    logic rx_frame_sync;
    logic rx_serial_in;
  } fsp_pins_in_type;

  typedef struct packed {
    logic tx_bit_clock;
    logic tx_bit_clock_oe_n;
    logic tx_frame_sync;
    logic tx_frame_sync_oe_n;
    logic tx_serial_out;
    logic tx_serial_out_oe_n;
    logic rx_bit_clock;
    logic rx_bit_clock_oe_n;
    logic rx_frame_sync;
    logic rx_frame_sync_oe_n;
  } fsp_pins_out_type;
endpackage : fsp_pkg

// ### rtl/fsp_top.sv
// Summary of operation
// - Two identical, independent ports, each with its own transmit and receive clock, frame sync and data pins.
// - The transmit frame sync pin is an input or an output as software selects.
// - The receive frame sync pin is an input or an output as software selects.
// - After reset every clock and frame sync pin is an input and is not driven.
// - Transmit data is open drain: the device only pulls it low or releases it.
// - The transmit bit clock pin is an input from the far end or an output made by the device.
// - The transmit bit clock runs between 512 KHz and 8.192 MHz, whichever side makes it; the device makes it only from about 556 KHz to 5 MHz.
// - Each outgoing bit is shifted onto the transmit data line in step with the transmit bit clock.
// - Transmit frame sync and data change on the rising or the falling clock edge as software selects.
// - The receive bit clock pin is an input from the far end or an output made by the device.
// - The receive bit clock runs within the port's supported span, whichever side makes it.
// - Each incoming bit is captured using the receive bit clock as the sampling reference.
// - Receive data is sampled on the rising or the falling clock edge as software selects.
//
// Local design decisions: register access over APB and the register addresses.

`timescale 1ns/10ps

module fsp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [PW-1:0] wr_ptr_r;
  logic [PW-1:0] rd_ptr_r;
  logic [PW:0] count_r;
  logic push;
  logic pop;
  assign in_ready = (count_r != (PW+1)'(DEPTH));
  assign out_valid = (count_r != '0);
  assign out_data = mem_r[rd_ptr_r];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
    ptr_inc = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
  endfunction : ptr_inc

  always_ff @(posedge pclk) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= ptr_inc(wr_ptr_r);
      end
      if (pop) begin
        rd_ptr_r <= ptr_inc(rd_ptr_r);
      end
      if (push && !pop) begin
        count_r <= count_r + (PW+1)'(1);
      end else if (pop && !push) begin
        count_r <= count_r - (PW+1)'(1);
      end
    end
  end
endmodule : fsp_fifo

module fsp_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [fsp_pkg::ADDR_BITS-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire fsp_pkg::fsp_pins_in_type [fsp_pkg::NUM_PORTS-1:0] pins_in,
  output fsp_pkg::fsp_pins_out_type [fsp_pkg::NUM_PORTS-1:0] pins_out
);
  localparam int NP = fsp_pkg::NUM_PORTS;
  localparam int WB = fsp_pkg::WORD_BITS;
  logic [fsp_pkg::CTRL_BITS-1:0] ctrl_r [NP];
  logic [fsp_pkg::DIV_BITS-1:0] div_r [NP];
  logic [NP-1:0] tx_in_ready;
  logic [NP-1:0] tx_out_valid;
  logic [NP-1:0] rx_out_valid;
  logic [WB-1:0] rx_out_data [NP];
  logic [NP-1:0] rx_ovf_r;
  logic [NP-1:0] tx_push;
  logic [NP-1:0] rx_pop;
  logic [NP-1:0] ovf_clear;
  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;
  logic access;
  logic mapped;
  logic port_sel;
  logic [3:0] reg_ofs;
  logic commit;
  // Picks the edge that belongs to the selected polarity.
  function automatic logic edge_pick(input logic falling, input logic rise, input logic fall);
    edge_pick = falling ? fall : rise;
  endfunction : edge_pick
  assign access = psel & penable & ~pready_r;
  assign mapped = (paddr >= fsp_pkg::ADDR_BITS'(NP * fsp_pkg::PORT_STRIDE)) ? 1'b0 : (paddr[1:0] == 2'h0);
  assign port_sel = paddr[4];
  assign reg_ofs = paddr[3:0];
  // A data write to a full transmit buffer holds the access phase until room appears.
  assign commit = access & ~(mapped & pwrite & (reg_ofs == fsp_pkg::OFS_DATA) & ~tx_in_ready[port_sel]);
  always_comb begin
    for (int i = 0; i < NP; i++) begin
      tx_push[i] = commit & mapped & pwrite & (reg_ofs == fsp_pkg::OFS_DATA) & (port_sel == 1'(i));
      rx_pop[i] = commit & mapped & ~pwrite & (reg_ofs == fsp_pkg::OFS_DATA) & (port_sel == 1'(i));
      ovf_clear[i] = commit & mapped & pwrite & (reg_ofs == fsp_pkg::OFS_STATUS) & (port_sel == 1'(i))
                     & pwdata[fsp_pkg::STAT_RX_OVF];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      pready_r <= commit;
      pslverr_r <= commit & ~mapped;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h00000000;
    end else if (commit && !pwrite && mapped) begin
      unique case (reg_ofs)
        fsp_pkg::OFS_CTRL: prdata_r <= 32'(ctrl_r[port_sel]);
        fsp_pkg::OFS_DIV: prdata_r <= 32'(div_r[port_sel]);
        fsp_pkg::OFS_DATA: prdata_r <= rx_out_valid[port_sel] ? 32'(rx_out_data[port_sel]) : 32'h00000000;
        fsp_pkg::OFS_STATUS: prdata_r <= 32'({rx_ovf_r[port_sel], rx_out_valid[port_sel],
                                               ~tx_out_valid[port_sel], ~tx_in_ready[port_sel]});
        default: prdata_r <= 32'h00000000;
      endcase
    end else if (commit) begin
      prdata_r <= 32'h00000000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NP; i++) begin
        ctrl_r[i] <= fsp_pkg::CTRL_RESET;
        div_r[i] <= fsp_pkg::DIV_RESET;
      end
    end else if (commit && pwrite && mapped) begin
      if (reg_ofs == fsp_pkg::OFS_CTRL) begin
        ctrl_r[port_sel] <= pwdata[fsp_pkg::CTRL_BITS-1:0];
      end
      if (reg_ofs == fsp_pkg::OFS_DIV) begin
        // The divider is clamped so that a generated clock never drops below the lowest rate.
        div_r[port_sel] <= (pwdata[31:fsp_pkg::DIV_BITS] != '0 || pwdata[fsp_pkg::DIV_BITS-1:0] > fsp_pkg::DIV_MAX)
                           ? fsp_pkg::DIV_MAX : pwdata[fsp_pkg::DIV_BITS-1:0];
      end
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;

  for (genvar p = 0; p < NP; p++) begin : g_port
    fsp_pkg::fsp_pins_in_type s1_r;
    fsp_pkg::fsp_pins_in_type s2_r;
    fsp_pkg::fsp_pins_in_type s3_r;
    logic [fsp_pkg::DIV_BITS-1:0] gen_cnt_r;
    logic gen_clk_r;
    logic gen_tick;
    logic tx_rise;
    logic tx_fall;
    logic rx_rise;
    logic rx_fall;
    logic launch;
    logic sample;
    logic rx_other;
    logic tx_start;
    logic rx_start;
    logic [WB-1:0] tx_word;
    logic [WB-1:0] tx_sr_r;
    logic [2:0] tx_cnt_r;
    logic tx_rel_r;
    logic tx_fs_r;
    logic [WB-1:0] rx_sr_r;
    logic [2:0] rx_cnt_r;
    logic rx_fs_r;
    logic rx_push;
    logic rx_in_ready;
    logic [WB-1:0] rx_word;
    logic [fsp_pkg::CTRL_BITS-1:0] c;
    assign c = ctrl_r[p];
    // Pins idle at their pull-up level, so the synchronisers start high and no false edge follows reset.
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        s1_r <= '1;
        s2_r <= '1;
        s3_r <= '1;
      end else begin
        s1_r <= pins_in[p];
        s2_r <= s1_r;
        s3_r <= s2_r;
      end
    end
    // A divider lowered below the running count ends the half period at once instead of wrapping.
    assign gen_tick = (gen_cnt_r >= div_r[p]);
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        gen_cnt_r <= fsp_pkg::DIV_MIN;
        gen_clk_r <= 1'b0;
      end else if (gen_tick) begin
        gen_cnt_r <= fsp_pkg::DIV_MIN;
        gen_clk_r <= ~gen_clk_r;
      end else begin
        gen_cnt_r <= gen_cnt_r + fsp_pkg::DIV_BITS'(1);
      end
    end

    assign tx_rise = c[fsp_pkg::CTRL_TX_CLK_OUT] ? (gen_tick & ~gen_clk_r) : (s2_r.tx_bit_clock & ~s3_r.tx_bit_clock);
    assign tx_fall = c[fsp_pkg::CTRL_TX_CLK_OUT] ? (gen_tick & gen_clk_r) : (~s2_r.tx_bit_clock & s3_r.tx_bit_clock);
    assign rx_rise = c[fsp_pkg::CTRL_RX_CLK_OUT] ? (gen_tick & ~gen_clk_r) : (s2_r.rx_bit_clock & ~s3_r.rx_bit_clock);
    assign rx_fall = c[fsp_pkg::CTRL_RX_CLK_OUT] ? (gen_tick & gen_clk_r) : (~s2_r.rx_bit_clock & s3_r.rx_bit_clock);
    assign launch = edge_pick(c[fsp_pkg::CTRL_TX_FALL], tx_rise, tx_fall);
    assign sample = edge_pick(c[fsp_pkg::CTRL_RX_FALL], rx_rise, rx_fall);
    assign rx_other = edge_pick(~c[fsp_pkg::CTRL_RX_FALL], rx_rise, rx_fall);

    assign tx_start = c[fsp_pkg::CTRL_TX_FS_OUT] ? (tx_cnt_r == 3'h0) : s2_r.tx_frame_sync;
    assign rx_start = c[fsp_pkg::CTRL_RX_FS_OUT] ? (rx_cnt_r == 3'h0) : s2_r.rx_frame_sync;

    fsp_fifo #(.WIDTH(WB), .DEPTH(fsp_pkg::FIFO_DEPTH)) u_tx_fifo (
      .pclk(pclk),
      .presetn(presetn),
      .in_valid(tx_push[p]),
      .in_ready(tx_in_ready[p]),
      .in_data(pwdata[WB-1:0]),
      .out_valid(tx_out_valid[p]),
      .out_ready(launch & tx_start),
      .out_data(tx_word)
    );
    // An empty buffer at a frame start sends an idle word that leaves the line released.
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        tx_sr_r <= fsp_pkg::IDLE_WORD;
        tx_cnt_r <= 3'h0;
        tx_rel_r <= 1'b1;
        tx_fs_r <= 1'b0;
      end else if (launch) begin
        if (tx_start) begin
          tx_rel_r <= tx_out_valid[p] ? tx_word[WB-1] : 1'b1;
          tx_sr_r <= tx_out_valid[p] ? {tx_word[WB-2:0], 1'b1} : fsp_pkg::IDLE_WORD;
          tx_cnt_r <= 3'h1;
          tx_fs_r <= 1'b1;
        end else if (tx_cnt_r != 3'h0) begin
          tx_rel_r <= tx_sr_r[WB-1];
          tx_sr_r <= {tx_sr_r[WB-2:0], 1'b1};
          tx_cnt_r <= tx_cnt_r + 3'h1;
          tx_fs_r <= 1'b0;
        end else begin
          tx_rel_r <= 1'b1;
          tx_fs_r <= 1'b0;
        end
      end
    end
    assign rx_word = {rx_sr_r[WB-2:0], s2_r.rx_serial_in};
    assign rx_push = sample & (rx_cnt_r == 3'h7) & ~(rx_start & ~c[fsp_pkg::CTRL_RX_FS_OUT]);
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        rx_sr_r <= '0;
        rx_cnt_r <= 3'h0;
      end else if (sample) begin
        if (rx_start) begin
          rx_sr_r <= rx_word;
          rx_cnt_r <= 3'h1;
        end else if (rx_cnt_r != 3'h0) begin
          rx_sr_r <= rx_word;
          rx_cnt_r <= rx_cnt_r + 3'h1;
        end
      end
    end
    // A generated receive frame sync changes on the edge opposite the sampling edge.
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        rx_fs_r <= 1'b0;
      end else if (rx_other) begin
        rx_fs_r <= (rx_cnt_r == 3'h0);
      end
    end
    fsp_fifo #(.WIDTH(WB), .DEPTH(fsp_pkg::FIFO_DEPTH)) u_rx_fifo (
      .pclk(pclk),
      .presetn(presetn),
      .in_valid(rx_push),
      .in_ready(rx_in_ready),
      .in_data(rx_word),
      .out_valid(rx_out_valid[p]),
      .out_ready(rx_pop[p]),
      .out_data(rx_out_data[p])
    );
    // A lost word wins over a clear in the same cycle.
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        rx_ovf_r[p] <= 1'b0;
      end else if (rx_push && !rx_in_ready) begin
        rx_ovf_r[p] <= 1'b1;
      end else if (ovf_clear[p]) begin
        rx_ovf_r[p] <= 1'b0;
      end
    end
    assign pins_out[p] = '{
      tx_bit_clock: gen_clk_r,
      tx_bit_clock_oe_n: ~c[fsp_pkg::CTRL_TX_CLK_OUT],
      tx_frame_sync: tx_fs_r,
      tx_frame_sync_oe_n: ~c[fsp_pkg::CTRL_TX_FS_OUT],
      tx_serial_out: 1'b0,
      tx_serial_out_oe_n: tx_rel_r,
      rx_bit_clock: gen_clk_r,
      rx_bit_clock_oe_n: ~c[fsp_pkg::CTRL_RX_CLK_OUT],
      rx_frame_sync: rx_fs_r,
      rx_frame_sync_oe_n: ~c[fsp_pkg::CTRL_RX_FS_OUT]
    };
  end
endmodule : fsp_top

// ### test/fsp_top_sva.sv
`timescale 1ns/10ps
module fsp_top_sva (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [fsp_pkg::ADDR_BITS-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire fsp_pkg::fsp_pins_out_type [fsp_pkg::NUM_PORTS-1:0] pins_out
);
  logic idle_pins;
  logic [3:0] hold_r;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence ctrl0_wr;
    psel && penable && pwrite && paddr == 12'h000 ##1 pready;
  endsequence
  always_comb begin
    idle_pins = 1'b1;
    for (int p = 0; p < fsp_pkg::NUM_PORTS; p++) begin
      idle_pins &= pins_out[p].tx_bit_clock_oe_n & pins_out[p].tx_frame_sync_oe_n & pins_out[p].tx_serial_out_oe_n
        & pins_out[p].rx_bit_clock_oe_n & pins_out[p].rx_frame_sync_oe_n;
    end
  end
  // Counts how long the driven transmit bit clock of port 0 has held its level.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_r <= 4'h0;
    end else if (pins_out[0].tx_bit_clock_oe_n || $changed(pins_out[0].tx_bit_clock)) begin
      hold_r <= 4'h0;
    end else begin
      hold_r <= hold_r + 4'h1;
    end
  end
  pin_reset_a: assert property ($rose(presetn) |-> idle_pins)
    else $error("pin driven after reset");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  ready_cause_a: assert property (pready |-> $past(psel && penable))
    else $error("pready without access");
  bad_addr_a: assert property (pready && (paddr >= 12'h020 || paddr[1:0] != 2'h0) |-> pslverr)
    else $error("unmapped access not refused");
  good_addr_a: assert property (pready && paddr < 12'h020 && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("mapped access refused");
  wr_data_a: assert property (pready && pwrite |-> prdata == 32'h0)
    else $error("read data on write");
  od_low_a: assert property (!pins_out[0].tx_serial_out && !pins_out[1].tx_serial_out)
    else $error("transmit line driven high");
  clk_span_a: assert property (hold_r < 4'h9)
    else $error("bit clock half period too long");
  fs_dir_a: assert property ($fell(pins_out[0].tx_frame_sync_oe_n) |-> $past(psel && penable && pwrite))
    else $error("frame sync driven without write");
  rx_fs_dir_a: assert property (ctrl0_wr |=> pins_out[0].rx_frame_sync_oe_n != $past(pwdata[3]))
    else $error("receive frame sync direction wrong");
endmodule : fsp_top_sva

bind fsp_top fsp_top_sva i_sva (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pins_out(pins_out));

// ### test/fsp_far_end.sv
`timescale 1ns/10ps
module fsp_far_end (
  output logic bit_clock,
  output logic frame_sync,
  output logic serial_data,
  input wire logic line_in,
  input wire logic invert
);
  logic phase;
  assign bit_clock = phase ^ invert;
  initial begin
    phase = 1'b0;
    frame_sync = 1'b0;
    serial_data = 1'b1;
  end
  // Sends one byte MSB first, captures the byte launched back, then leaves the clock idle for half a bit.
  task automatic frame(input logic [7:0] rx_byte, output logic [7:0] tx_byte);
    for (int i = 7; i >= 0; i--) begin
      frame_sync <= (i == 7);
      serial_data <= rx_byte[i];
      #400 phase <= 1'b1;
      #400 phase <= 1'b0;
      tx_byte[i] = line_in;
    end
    frame_sync <= 1'b0;
    serial_data <= 1'b1;
    #400;
  endtask : frame
endmodule : fsp_far_end

// ### test/tb.sv
`timescale 1ns/10ps
module tb;
  localparam logic [4:0] DIR_OE [4] = '{5'h0F, 5'h17, 5'h1D, 5'h1E};
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [fsp_pkg::ADDR_BITS-1:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  fsp_pkg::fsp_pins_in_type [fsp_pkg::NUM_PORTS-1:0] pins_in;
  fsp_pkg::fsp_pins_out_type [fsp_pkg::NUM_PORTS-1:0] pins_out;
  logic [9:0] oe_all;
  logic [1:0] line;
  logic far_clk;
  logic far_fs;
  logic far_sd;
  logic inv;
  logic [31:0] rd;
  logic err;
  logic [7:0] got;
  int h;
  int fails;
  int checks_done;
  fsp_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pins_in(pins_in), .pins_out(pins_out));
  fsp_far_end i_far (.bit_clock(far_clk), .frame_sync(far_fs), .serial_data(far_sd), .line_in(line[1]),
    .invert(inv));
  // Undriven port 0 pins sit at their pull-up level; transmit data is open drain.
  always_comb begin
    for (int p = 0; p < 2; p++) begin
      pins_in[p].tx_bit_clock = pins_out[p].tx_bit_clock_oe_n ? ((p == 0) | far_clk) : pins_out[p].tx_bit_clock;
      pins_in[p].rx_bit_clock = pins_out[p].rx_bit_clock_oe_n ? ((p == 0) | far_clk) : pins_out[p].rx_bit_clock;
      pins_in[p].tx_frame_sync = pins_out[p].tx_frame_sync_oe_n ? ((p == 0) | far_fs) : pins_out[p].tx_frame_sync;
      pins_in[p].rx_frame_sync = pins_out[p].rx_frame_sync_oe_n ? ((p == 0) | far_fs) : pins_out[p].rx_frame_sync;
      line[p] = pins_out[p].tx_serial_out_oe_n | pins_out[p].tx_serial_out;
      oe_all[p*5 +: 5] = {pins_out[p].tx_bit_clock_oe_n, pins_out[p].tx_frame_sync_oe_n,
        pins_out[p].tx_serial_out_oe_n, pins_out[p].rx_bit_clock_oe_n, pins_out[p].rx_frame_sync_oe_n};
    end
    pins_in[0].rx_serial_in = line[0];
    pins_in[1].rx_serial_in = far_sd;
  end
  function automatic logic [7:0] tx_of(int m, int k);
    return 8'(8'h96 + k * 53 + m * 7);
  endfunction : tx_of
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
    output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rd, err);
  endtask : wr
  task automatic rd_chk(input string what, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, rd, err);
    chk(what, rd, exp);
  endtask : rd_chk
  task automatic half(output int n);
    logic v;
    for (int k = 0; k < 3; k++) begin
      n = 0;
      v = pins_out[0].tx_bit_clock;
      while (pins_out[0].tx_bit_clock === v && n < 20) begin
        @(negedge pclk);
        n++;
      end
    end
  endtask : half
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  initial begin
    #2000000;
    fails++;
    tally_and_finish();
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, inv} = '0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    chk("oe reset", {22'h0, oe_all}, 32'h3FF);
    rd_chk("ctrl reset", 12'h000, {26'h0, fsp_pkg::CTRL_RESET});
    rd_chk("status reset", 12'h01C, 32'h2);
    apb(1'b0, 12'h020, 32'h0, rd, err);
    chk("unmapped", {31'h0, err}, 32'h1);
    apb(1'b1, 12'h006, 32'hF, rd, err);
    chk("misaligned", {31'h0, err}, 32'h1);
    rd_chk("div reset", 12'h004, {28'h0, fsp_pkg::DIV_RESET});
    for (int i = 0; i < 4; i++) begin
      wr(12'h000, 32'(1 << i));
      @(negedge pclk);
      chk("oe dir", {22'h0, oe_all}, {22'h0, 5'h1F, DIR_OE[i]});
    end
    wr(12'h000, 32'h1);
    wr(12'h004, 32'h0);
    half(h);
    chk("half min", 32'(h), 32'h1);
    wr(12'h004, 32'hF);
    half(h);
    chk("half max", 32'(h), {28'h0, fsp_pkg::DIV_MAX} + 32'h1);
    for (int m = 0; m < 2; m++) begin
      inv <= m[0];
      wr(12'h010, (m == 1) ? 32'h30 : 32'h0);
      for (int k = 0; k < 4; k++) wr(12'h018, {24'h0, tx_of(m, k)});
      rd_chk("status full", 12'h01C, 32'h1);
      for (int k = 0; k < 5; k++) begin
        if (m == 1 && k == 0) begin
          // A fifth data write to the full buffer stalls until the first frame pops a word.
          fork
            wr(12'h018, {24'h0, tx_of(m, 4)});
            i_far.frame(~tx_of(m, k), got);
          join
        end else begin
          i_far.frame(~tx_of(m, k), got);
        end
        chk("tx byte", {24'h0, got}, (k < 4 || m == 1) ? {24'h0, tx_of(m, k)} : 32'hFF);
      end
      rd_chk("status ovf", 12'h01C, 32'hE);
      for (int k = 0; k < 4; k++) rd_chk("rx byte", 12'h018, {24'h0, ~tx_of(m, k)});
      rd_chk("status drained", 12'h01C, 32'hA);
      wr(12'h01C, 32'h8);
      rd_chk("status clear", 12'h01C, 32'h2);
    end
    tally_and_finish();
  end
endmodule : tb
